// ---- logic/tpi_cfg.svh ----
// Register offsets, field positions and fixed values of the trace port test logic
`ifndef TPI_CFG_SVH
`define TPI_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TPI_OFS_INSTR_DATA 12'heec
`define TPI_OFS_READY_DRIVE 12'hef0
`define TPI_OFS_VALID_OBS 12'hef8
`define TPI_OFS_SW_DATA 12'hefc
`define TPI_OFS_MODE_CTRL 12'hf00
`define TPI_OFS_CAPABILITY 12'hfc8

// ----------------------------------------------------------------------------
// Integration data register fields
// ----------------------------------------------------------------------------
`define TPI_SW_VALID_BIT 29
`define TPI_SW_COUNT_LSB 27
`define TPI_INSTR_VALID_BIT 26
`define TPI_INSTR_COUNT_LSB 24
`define TPI_BYTE_W 8
`define TPI_SLOTS 3
`define TPI_COUNT_MAX 2'h3
`define TPI_COUNT_ZERO 2'h0
`define TPI_COUNT_ONE 2'h1

// ----------------------------------------------------------------------------
// Mode field and capability fields
// ----------------------------------------------------------------------------
`define TPI_MODE_LSB 0
`define TPI_DRIVE_BIT 0
`define TPI_VALID_OBS_BIT 0
`define TPI_CAP_NRZ_BIT 11
`define TPI_CAP_MANCH_BIT 10
`define TPI_CAP_PARALLEL_BIT 9
`define TPI_CAP_QUEUE_LSB 6
`define TPI_CAP_QUEUE_SIZE 3'h2
`define TPI_CAP_INPUTS_LSB 0
`define TPI_CAP_ONE_INPUT 6'h00
`define TPI_CAP_TWO_INPUTS 6'h01

// Source indices
`define TPI_SRC_INSTR 0
`define TPI_SRC_SW 1

`endif

// ---- logic/tpi_pkg.sv ----
// Types shared by the trace port test logic
`default_nettype none
package tpi_pkg;

    typedef enum logic [1:0] {
        TPI_MODE_NORMAL = 2'h0,
        TPI_MODE_ITEST = 2'h1,
        TPI_MODE_IDATA = 2'h2,
        TPI_MODE_RSVD = 2'h3
    } tpi_mode_t;

    // Whole register state of the block, one flop set
    typedef struct packed {
        tpi_mode_t mode;
        logic drive;
        logic [1:0][1:0] count;
        logic [1:0][2:0][7:0] bytes;
        logic [1:0] ready;
        logic trace_en;
        logic [31:0] rdata;
    } tpi_state_t;

endpackage
`default_nettype wire

// ---- logic/tpi_top.sv ----
// Integration test and capability registers of the trace port unit
//
// What this block does
// - Bit 29 of both data registers shows live software-trace valid input.
// - Bits 28:27 count software-trace bytes since last software-data register read.
// - Bit 26 of both data registers shows live instruction-trace valid input.
// - Bits 25:24 count instruction-trace bytes since last instruction-data read.
// - Instruction-data register shows three captured bytes; reading discards them.
// - Software-data register shows three captured bytes; reading discards them.
// - In integration test mode, ready drive bit 0 sets both ready outputs.
// - Valid observe bit 0 reads OR of both valid inputs.
// - Mode field 0 normal, 1 integration test, 2 data test, 3 reserved.
// - Data test mode disables trace output; inputs read through data registers.
// - Capability bit 11 always reads one, NRZ output supported.
// - Capability bit 10 always reads one, Manchester output supported.
// - Capability bit 9 always reads zero, parallel port supported.
// - Capability bits 8:6 read 2, four-byte output queue.
// - Capability bits 5:0 read one when instruction source present (two inputs), else zero.
`include "tpi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tpi_top #(
    parameter int ADDR_W = 12,
    parameter bit HAS_INSTR_SRC = 1'b1
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic instr_valid_in,
    input wire logic [7:0] instr_data_in,
    output logic instr_ready_out,
    input wire logic sw_valid_in,
    input wire logic [7:0] sw_data_in,
    output logic sw_ready_out,
    input wire logic sink_ready_in,
    output logic trace_out_en_out
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (ADDR_W < 12)
    begin : g_bad_addr
        $error("tpi_top: ADDR_W must be at least 12");
    end

    // ------------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------------
    tpi_pkg::tpi_state_t st;
    tpi_pkg::tpi_state_t next_st;

    logic [11:0] ofs;
    logic [1:0] valid;
    logic [1:0][7:0] din;
    logic [1:0] take;
    logic [1:0] rd_clr;
    logic [5:0] inputs_field;

    // Only the low 12 bits select a register; the block fills a 4 KB frame
    assign ofs = reg_addr_in[11:0];
    assign valid = {sw_valid_in, instr_valid_in};
    assign din = {sw_data_in, instr_data_in};
    assign inputs_field = HAS_INSTR_SRC ? `TPI_CAP_TWO_INPUTS : `TPI_CAP_ONE_INPUT;

    // ------------------------------------------------------------------------
    // Per-source capture strobes
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_src
        // Bytes are taken only in data test mode, on an accepted beat
        assign take[i] = (st.mode == tpi_pkg::TPI_MODE_IDATA) && valid[i] && st.ready[i];
    end
    assign rd_clr[`TPI_SRC_INSTR] = reg_rd_in && (ofs == `TPI_OFS_INSTR_DATA);
    assign rd_clr[`TPI_SRC_SW] = reg_rd_in && (ofs == `TPI_OFS_SW_DATA);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        logic [1:0] cnt;
        logic [31:0] status;
        cnt = `TPI_COUNT_ZERO;
        status = 32'h0000_0000;
        next_st = st;

        // Register writes; only defined fields are stored
        if (reg_wr_in)
        begin
            case (ofs)
                `TPI_OFS_MODE_CTRL:
                begin
                    next_st.mode = tpi_pkg::tpi_mode_t'(reg_wdata_in[`TPI_MODE_LSB +: 2]);
                end
                `TPI_OFS_READY_DRIVE:
                begin
                    next_st.drive = reg_wdata_in[`TPI_DRIVE_BIT];
                end
                default:
                begin
                    next_st.drive = st.drive;
                end
            endcase
        end

        // Capture and count; a byte landing in the read cycle survives the clear
        for (int s = 0; s < 2; s++)
        begin
            cnt = rd_clr[s] ? `TPI_COUNT_ZERO : st.count[s];
            if (rd_clr[s])
            begin
                next_st.bytes[s] = '0;
            end
            if (take[s])
            begin
                if (cnt != `TPI_COUNT_MAX)
                begin
                    next_st.bytes[s][cnt] = din[s];
                    cnt = cnt + `TPI_COUNT_ONE;
                end
            end
            next_st.count[s] = cnt;
        end

        // Ready outputs per mode
        for (int s = 0; s < 2; s++)
        begin
            case (next_st.mode)
                tpi_pkg::TPI_MODE_NORMAL: next_st.ready[s] = sink_ready_in;
                tpi_pkg::TPI_MODE_ITEST: next_st.ready[s] = next_st.drive;
                // Back-pressure once all three slots hold a byte
                tpi_pkg::TPI_MODE_IDATA: next_st.ready[s] = next_st.count[s] != `TPI_COUNT_MAX;
                default: next_st.ready[s] = 1'b0;
            endcase
        end
        next_st.trace_en = next_st.mode != tpi_pkg::TPI_MODE_IDATA;

        // Live valid inputs and counts common to both data registers
        status[`TPI_SW_VALID_BIT] = sw_valid_in;
        status[`TPI_SW_COUNT_LSB +: 2] = st.count[`TPI_SRC_SW];
        status[`TPI_INSTR_VALID_BIT] = instr_valid_in;
        status[`TPI_INSTR_COUNT_LSB +: 2] = st.count[`TPI_SRC_INSTR];

        // Read data stand for exactly the cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (reg_rd_in)
        begin
            case (ofs)
                `TPI_OFS_INSTR_DATA:
                begin
                    next_st.rdata = status | {8'h00, st.bytes[`TPI_SRC_INSTR]};
                end
                `TPI_OFS_SW_DATA:
                begin
                    next_st.rdata = status | {8'h00, st.bytes[`TPI_SRC_SW]};
                end
                `TPI_OFS_READY_DRIVE:
                begin
                    next_st.rdata[`TPI_DRIVE_BIT] = st.drive;
                end
                `TPI_OFS_VALID_OBS:
                begin
                    next_st.rdata[`TPI_VALID_OBS_BIT] = instr_valid_in | sw_valid_in;
                end
                `TPI_OFS_MODE_CTRL:
                begin
                    next_st.rdata[`TPI_MODE_LSB +: 2] = st.mode;
                end
                `TPI_OFS_CAPABILITY:
                begin
                    next_st.rdata[`TPI_CAP_NRZ_BIT] = 1'b1;
                    next_st.rdata[`TPI_CAP_MANCH_BIT] = 1'b1;
                    next_st.rdata[`TPI_CAP_PARALLEL_BIT] = 1'b0;
                    next_st.rdata[`TPI_CAP_QUEUE_LSB +: 3] = `TPI_CAP_QUEUE_SIZE;
                    next_st.rdata[`TPI_CAP_INPUTS_LSB +: 6] = inputs_field;
                end
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign instr_ready_out = st.ready[`TPI_SRC_INSTR];
    assign sw_ready_out = st.ready[`TPI_SRC_SW];
    assign trace_out_en_out = st.trace_en;

endmodule
`default_nettype wire

// ---- tb/tpi_top_asserts.sv ----
// Port-level assertions for the trace port test logic
`timescale 1ns/1ps
`default_nettype none
module tpi_top_asserts #(
    parameter int ADDR_W = 12,
    parameter bit HAS_INSTR_SRC = 1'b1
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic instr_valid_in,
    input wire logic instr_ready_out,
    input wire logic sw_valid_in,
    input wire logic sw_ready_out,
    input wire logic sink_ready_in,
    input wire logic trace_out_en_out
);
    logic [1:0] md;
    logic [11:0] a;
    assign a = reg_addr_in[11:0];
    // Mode shadow: ready and enable checks depend on it
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            md <= 2'h0;
        else if (reg_wr_in && a == 12'hf00)
            md <= reg_wdata_in[1:0];
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    a_cap_word: assert property (reg_rd_in && a == 12'hfc8 |=>
        reg_rdata_out == (32'hc80 | 32'(HAS_INSTR_SRC))) else $error("bad capability");
    a_obs_or: assert property (reg_rd_in && a == 12'hef8 |=>
        reg_rdata_out == {31'h0, $past(instr_valid_in) | $past(sw_valid_in)}) else $error("bad or");
    a_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero");
    a_live_valid: assert property (reg_rd_in && a == 12'heec |=>
        reg_rdata_out[31:29] == {2'h0, $past(sw_valid_in)}
        && reg_rdata_out[26] == $past(instr_valid_in)) else $error("bad valid bits");
    a_drive_rdy: assert property (md == 2'h1 && reg_wr_in && a == 12'hef0 |=>
        {instr_ready_out, sw_ready_out} == {2{$past(reg_wdata_in[0])}}) else $error("bad drive");
    a_norm_rdy: assert property (md == 2'h0 && !$past(rst_in) && !(reg_wr_in && a == 12'hf00)
        |=> {instr_ready_out, sw_ready_out} == {2{$past(sink_ready_in)}}) else $error("bad ready");
    a_trace_en: assert property (!$past(rst_in) && md == $past(md) |->
        trace_out_en_out == (md != 2'h2)) else $error("bad trace enable");
    a_clr_read: assert property (reg_rd_in && a == 12'hefc && !sw_valid_in ##1
        reg_rd_in && a == 12'hefc |=> reg_rdata_out[28:27] == 2'h0
        && reg_rdata_out[23:0] == 24'h0) else $error("read did not clear");
endmodule
bind tpi_top tpi_top_asserts #(.ADDR_W(ADDR_W), .HAS_INSTR_SRC(HAS_INSTR_SRC)) u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .instr_valid_in(instr_valid_in),
    .instr_ready_out(instr_ready_out), .sw_valid_in(sw_valid_in), .sw_ready_out(sw_ready_out),
    .sink_ready_in(sink_ready_in), .trace_out_en_out(trace_out_en_out));
`default_nettype wire

// ---- tb/tpi_src_model.sv ----
// Behavioural trace source: offers bytes, holds each until taken
`timescale 1ns/1ps
`default_nettype none
module tpi_src_model #(
    parameter int SEED = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [7:0] data_out
);
    int seed = SEED;
    initial valid_out = 1'b0;
    initial data_out = 8'h00;
    // Idle data churns so a stale byte never looks like a beat
    always @(posedge clk_in)
    begin
        if (rst_in)
            valid_out <= 1'b0;
        else if (!valid_out || ready_in)
        begin
            valid_out <= ($random(seed) & 3) != 0;
            data_out <= 8'($random(seed));
        end
    end
endmodule
`default_nettype wire

// ---- tb/trace_port_integration_test_tb.sv ----
// Self-checking bench for the trace port test logic
`timescale 1ns/1ps
`default_nettype none
module trace_port_integration_test_tb;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic sink_ready_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] exp_rd;
    wire logic [31:0] reg_rdata_out;
    wire logic [1:0] vld, rdy;
    wire logic [7:0] dat [2];
    wire logic ten;
    logic [1:0] mode_m, cnt [2];
    logic [23:0] byt [2];
    logic drive_m, prev_sink, rd_pend, e;
    int errors = 0;
    int cmp_count = 0;
    int seed = 24492;
    int cycles = 0;
    int stable = 0;
    logic [11:0] map [7] = '{12'heec, 12'hef0, 12'hef8, 12'hefc, 12'hf00, 12'hfc8, 12'hf04};
    always #10 core_clk_in = ~core_clk_in;
    tpi_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .instr_valid_in(vld[0]), .instr_data_in(dat[0]),
        .instr_ready_out(rdy[0]), .sw_valid_in(vld[1]), .sw_data_in(dat[1]),
        .sw_ready_out(rdy[1]), .sink_ready_in(sink_ready_in), .trace_out_en_out(ten));
    tpi_src_model #(.SEED(3)) src_i (.clk_in(core_clk_in), .rst_in(rst_in), .ready_in(rdy[0]),
        .valid_out(vld[0]), .data_out(dat[0]));
    tpi_src_model #(.SEED(5)) src_s (.clk_in(core_clk_in), .rst_in(rst_in), .ready_in(rdy[1]),
        .valid_out(vld[1]), .data_out(dat[1]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        sink_ready_in <= 1'($random(seed));
        @(posedge core_clk_in);
    endtask
    // Reference model: sees pre-edge values, so it never races the design
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            errors++;
            results();
        end
        if (rst_in)
        begin
            mode_m = 2'h0;
            drive_m = 1'b0;
            cnt = '{2'h0, 2'h0};
            byt = '{24'h0, 24'h0};
            rd_pend = 1'b0;
            stable = 0;
        end
        else
        begin
            exp_rd = rd_pend ? exp_rd : 32'h0;
            chk(reg_rdata_out, exp_rd);
            if (stable > 1)
                chk(ten, mode_m != 2'h2);
            rd_pend = reg_rd_in;
            case (reg_addr_in)
                12'heec, 12'hefc:
                    exp_rd = {2'h0, vld[1], cnt[1], vld[0], cnt[0], byt[reg_addr_in[4]]};
                12'hef0: exp_rd = {31'h0, drive_m};
                12'hef8: exp_rd = {31'h0, vld[0] | vld[1]};
                12'hf00: exp_rd = {30'h0, mode_m};
                12'hfc8: exp_rd = 32'hc81;
                default: exp_rd = 32'h0;
            endcase
            for (int s = 0; s < 2; s++)
            begin
                e = mode_m == 2'h1 ? drive_m
                    : mode_m == 2'h0 ? prev_sink
                    : mode_m == 2'h2 && cnt[s] != 2'h3;
                if (stable > 1)
                    chk(rdy[s], e);
                if (reg_rd_in && reg_addr_in == (s ? 12'hefc : 12'heec))
                begin
                    cnt[s] = 2'h0;
                    byt[s] = 24'h0;
                end
                if (mode_m == 2'h2 && vld[s] && rdy[s] && cnt[s] != 2'h3)
                begin
                    byt[s][cnt[s]*8 +: 8] = dat[s];
                    cnt[s] = cnt[s] + 2'h1;
                end
            end
            if (reg_wr_in && reg_addr_in == 12'hf00)
            begin
                mode_m = reg_wdata_in[1:0];
                stable = 0;
            end
            if (reg_wr_in && reg_addr_in == 12'hef0)
                drive_m = reg_wdata_in[0];
            prev_sink = sink_ready_in;
            stable++;
        end
    end
    initial
    begin
        int k;
        repeat (16) @(posedge core_clk_in);
        rst_in <= 1'b0;
        foreach (map[i])
            op(1'b0, 1'b1, map[i], 32'h0);
        $display("test reset_map done");
        op(1'b1, 1'b0, 12'hf00, 32'hfffffffe);
        repeat (6) op(1'b0, 1'b0, 12'h0, 32'h0);
        op(1'b0, 1'b1, 12'hefc, 32'h0);
        op(1'b0, 1'b1, 12'hefc, 32'h0);
        op(1'b0, 1'b1, 12'heec, 32'h0);
        op(1'b1, 1'b0, 12'hf00, 32'h1);
        op(1'b1, 1'b0, 12'hef0, 32'h1);
        repeat (3) op(1'b0, 1'b1, 12'hef0, 32'h0);
        $display("test directed done");
        repeat (4000)
        begin
            k = $unsigned($random(seed)) % 4;
            op(k == 0, k == 1 || k == 2, map[$unsigned($random(seed)) % 7], $random(seed));
        end
        $display("test random done");
        results();
    end
endmodule
`default_nettype wire
